// file: hw/ldc_compat_regs.v
// legacy display compatibility register set with host i/o port decode
//
// Contract
// - video enable bit follows primary/alternate port
// - controller/mode/status ports follow emulation nibble
// - mode bit 6 reads page-enable bit 1
// - bit 5 makes background intensity blink
// - bit 3 keeps video during mode change
// - colour bit 4 selects 640x200 mode
// - colour bit 2 black-white versus colour
// - colour bit 1 graphics versus text
// - colour bit 0 80 versus 40 columns
// - mono bit 7 page, settable if enabled
// - mono bit 1 graphics, bit 0 columns
// - palette bit 5 picks two-bit pixel colours
// - palette bit 4 intensifies; register write-only
// - palette bits 3:0 background/foreground/border colour
// - 400-line register gated by control bits 7,6
// - underline attribute 01 replaces blue with underline
// - bit 3 picks 16KB page when no doublescan
// - bit 2 picks font block, default 0
// - bit 0 double-scans to 400 lines
// - page-enable bit 1 opens second page
// - sync-width bit 4 gives 16 or 2 lines
// - address select bit picks colour/mono range
// - disabled subsystem answers only enable register
`timescale 1ns/1ps
`include "ldc_regs.vh"

module ldc_compat_regs
(
  input  wire        MCLK_I,
  input  wire        RST_B_I,
  input  wire [15:0] IO_ADDR_I,
  input  wire        IO_WR_I,
  input  wire        IO_RD_I,
  input  wire [7:0]  IO_WDATA_I,
  output reg  [7:0]  IO_RDATA_O,
  output wire        IO_ACK_O,
  input  wire        ADDR_SELECT_COLOR_I,
  input  wire        VSE_ALT_PORT_I,
  input  wire [7:0]  COMPAT_CONTROL_I,
  input  wire        SYNC_WIDTH_NARROW_I,
  input  wire [1:0]  PIXEL_CODE_I,
  input  wire [7:0]  ATTRIBUTE_BYTE_I,
  output reg         VIDEO_ENABLE_O,
  output wire        CRT_IDX_SEL_O,
  output wire        CRT_DAT_SEL_O,
  output wire        STATUS_SEL_O,
  output reg         BLINK_ENABLE_O,
  output reg         VIDEO_KEEP_O,
  output reg         HIRES_MODE_O,
  output reg         BW_MODE_O,
  output reg         GRAPHICS_MODE_O,
  output reg         COL80_MODE_O,
  output reg         UPPER_PAGE_O,
  output reg         SECOND_PAGE_EN_O,
  output reg  [3:0]  PIXEL_COLOR_O,
  output reg  [3:0]  BASE_COLOR_O,
  output reg         UNDERLINE_EN_O,
  output reg         BLUE_SUPPRESS_O,
  output reg         ALT_PAGE_O,
  output reg         ALT_FONT_O,
  output reg         DOUBLE_SCAN_O,
  output reg  [4:0]  VSYNC_LINES_O
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  reg  [7:0] vse;
  reg  [7:0] mono_mode;
  reg  [7:0] page_en;
  reg  [7:0] colr_mode;
  reg  [7:0] palette;
  reg  [7:0] line400;

  wire [3:0] emu_nib;
  wire       vid_on;
  wire       hit_vse;
  wire       hit_mono;
  wire       hit_page;
  wire       hit_colr;
  wire       hit_pal;
  wire       hit_l400;
  wire       l400_en;
  wire       l400_dscan_ok;
  wire       l400_uline_ok;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // the enable register moves with the strap; only its current home answers
  assign hit_vse  = VSE_ALT_PORT_I ? (IO_ADDR_I == `LDC_ADDR_VSE_ALT)
                                   : (IO_ADDR_I == `LDC_ADDR_VSE_PRI);
  assign vid_on   = VSE_ALT_PORT_I ? vse[`LDC_VSE_ALT_BIT]
                                   : vse[`LDC_VSE_PRI_BIT];
  // middle nibble of the controller ports follows the emulation select
  assign emu_nib  = ADDR_SELECT_COLOR_I ? `LDC_EMU_COLR_NIB : `LDC_EMU_MONO_NIB;
  assign CRT_IDX_SEL_O = vid_on &&
    (IO_ADDR_I == {`LDC_PORT_HI, emu_nib, `LDC_NIB_CRT_IDX});
  assign CRT_DAT_SEL_O = vid_on &&
    (IO_ADDR_I == {`LDC_PORT_HI, emu_nib, `LDC_NIB_CRT_DAT});
  assign STATUS_SEL_O  = vid_on &&
    (IO_ADDR_I == {`LDC_PORT_HI, emu_nib, `LDC_NIB_STAT});
  // mode control sits at 3#8: mono copy in mono emulation, colour copy otherwise
  assign hit_mono = vid_on && !ADDR_SELECT_COLOR_I && (IO_ADDR_I == `LDC_ADDR_MONO_MODE);
  assign hit_colr = vid_on &&  ADDR_SELECT_COLOR_I && (IO_ADDR_I == `LDC_ADDR_COLR_MODE);
  assign hit_page = vid_on && (IO_ADDR_I == `LDC_ADDR_PAGE_EN);
  assign hit_pal  = vid_on && (IO_ADDR_I == `LDC_ADDR_PALETTE);
  assign hit_l400 = vid_on && (IO_ADDR_I == `LDC_ADDR_LINE400);
  assign IO_ACK_O = (IO_WR_I || IO_RD_I) &&
                    (hit_vse || hit_mono || hit_colr || hit_page || hit_pal || hit_l400 ||
                     CRT_IDX_SEL_O || CRT_DAT_SEL_O || STATUS_SEL_O);

  // 400-line register takes writes only with the compatibility enable set; its underline bit needs only control bit 6
  assign l400_en       = COMPAT_CONTROL_I[`LDC_CCR_ENABLE];
  assign l400_uline_ok = COMPAT_CONTROL_I[`LDC_CCR_ULINE_EN];
  assign l400_dscan_ok = l400_en && l400_uline_ok;

  ////////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits never stored
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      vse       <= `LDC_RST_VSE;
      mono_mode <= `LDC_RST_BYTE;
      page_en   <= `LDC_RST_BYTE;
      colr_mode <= `LDC_RST_BYTE;
      palette   <= `LDC_RST_BYTE;
      line400   <= `LDC_RST_BYTE;
    end
    else if (IO_WR_I)
    begin
      if (hit_vse)
        vse <= IO_WDATA_I & 8'h09;
      if (hit_mono)
      begin
        // page bit only takes a 1 while the second page is enabled
        mono_mode <= {IO_WDATA_I[7] & page_en[`LDC_PAGE_EN_BIT], 1'b0,
                      IO_WDATA_I[5], 1'b0, IO_WDATA_I[3], 1'b0, IO_WDATA_I[1:0]};
      end
      if (hit_page)
        page_en <= IO_WDATA_I & 8'h02;
      if (hit_colr)
        colr_mode <= IO_WDATA_I & 8'h3F;
      if (hit_pal)
        palette <= IO_WDATA_I & 8'h3F;
      // host owes us colour emulation here; hit_l400 does not check it
      if (hit_l400 && l400_en)
        line400 <= IO_WDATA_I & 8'h4D;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; write-only registers read zero, bit 6 mirrors page enable
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      IO_RDATA_O <= `LDC_RST_BYTE;
    else if (IO_RD_I)
    begin
      if (hit_vse)
        IO_RDATA_O <= vse;
      else if (hit_mono)
        IO_RDATA_O <= mono_mode | {1'b0, page_en[`LDC_PAGE_EN_BIT], 6'h00};
      else if (hit_colr)
        IO_RDATA_O <= colr_mode | {1'b0, page_en[`LDC_PAGE_EN_BIT], 6'h00};
      else
        IO_RDATA_O <= `LDC_RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode: the copy matching the emulation drives the display
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      VIDEO_ENABLE_O   <= 1'b0;
      BLINK_ENABLE_O   <= 1'b0;
      VIDEO_KEEP_O     <= 1'b0;
      HIRES_MODE_O     <= 1'b0;
      BW_MODE_O        <= 1'b0;
      GRAPHICS_MODE_O  <= 1'b0;
      COL80_MODE_O     <= 1'b0;
      UPPER_PAGE_O     <= 1'b0;
      SECOND_PAGE_EN_O <= 1'b0;
      ALT_PAGE_O       <= 1'b0;
      ALT_FONT_O       <= 1'b0;
      DOUBLE_SCAN_O    <= 1'b0;
      VSYNC_LINES_O    <= `LDC_VSYNC_WIDE;
    end
    else
    begin
      VIDEO_ENABLE_O <= vid_on;
      if (ADDR_SELECT_COLOR_I)
      begin
        BLINK_ENABLE_O  <= colr_mode[`LDC_MODE_BLINK];
        VIDEO_KEEP_O    <= colr_mode[`LDC_MODE_VIDEO];
        HIRES_MODE_O    <= colr_mode[`LDC_MODE_HIRES];
        BW_MODE_O       <= colr_mode[`LDC_MODE_BW];
        GRAPHICS_MODE_O <= colr_mode[`LDC_MODE_GFX];
        COL80_MODE_O    <= colr_mode[`LDC_MODE_COL80];
        UPPER_PAGE_O    <= 1'b0;
      end
      else
      begin
        BLINK_ENABLE_O  <= mono_mode[`LDC_MODE_BLINK];
        VIDEO_KEEP_O    <= mono_mode[`LDC_MODE_VIDEO];
        HIRES_MODE_O    <= 1'b0;
        BW_MODE_O       <= 1'b0;
        GRAPHICS_MODE_O <= mono_mode[`LDC_MODE_GFX];
        COL80_MODE_O    <= mono_mode[`LDC_MODE_COL80];
        UPPER_PAGE_O    <= mono_mode[`LDC_MODE_PAGE];
      end
      SECOND_PAGE_EN_O <= page_en[`LDC_PAGE_EN_BIT];
      // second 16KB page only shows without double scan
      ALT_PAGE_O    <= l400_en && line400[`LDC_L400_PAGE] && !line400[`LDC_L400_DSCAN];
      ALT_FONT_O    <= l400_en && line400[`LDC_L400_FONT];
      DOUBLE_SCAN_O <= l400_dscan_ok && line400[`LDC_L400_DSCAN];
      VSYNC_LINES_O <= SYNC_WIDTH_NARROW_I ? `LDC_VSYNC_NARROW : `LDC_VSYNC_WIDE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel colour path, registered one cycle after the pixel inputs
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      PIXEL_COLOR_O   <= 4'h0;
      BASE_COLOR_O    <= 4'h0;
      UNDERLINE_EN_O  <= 1'b0;
      BLUE_SUPPRESS_O <= 1'b0;
    end
    else
    begin
      // border / background / foreground depending on mode
      BASE_COLOR_O <= palette[3:0];
      if (PIXEL_CODE_I == 2'b00)
        PIXEL_COLOR_O <= palette[3:0];
      else
        case ({palette[`LDC_PAL_SET], PIXEL_CODE_I})
          3'b101:  PIXEL_COLOR_O <= `LDC_COL_CYAN    | (palette[`LDC_PAL_INTENS] ? `LDC_COL_INTENS : 4'h0);
          3'b110:  PIXEL_COLOR_O <= `LDC_COL_MAGENTA | (palette[`LDC_PAL_INTENS] ? `LDC_COL_INTENS : 4'h0);
          3'b111:  PIXEL_COLOR_O <= `LDC_COL_WHITE   | (palette[`LDC_PAL_INTENS] ? `LDC_COL_INTENS : 4'h0);
          3'b001:  PIXEL_COLOR_O <= `LDC_COL_GREEN   | (palette[`LDC_PAL_INTENS] ? `LDC_COL_INTENS : 4'h0);
          3'b010:  PIXEL_COLOR_O <= `LDC_COL_RED     | (palette[`LDC_PAL_INTENS] ? `LDC_COL_INTENS : 4'h0);
          3'b011:  PIXEL_COLOR_O <= `LDC_COL_BROWN   | (palette[`LDC_PAL_INTENS] ? `LDC_COL_INTENS : 4'h0);
          default: PIXEL_COLOR_O <= palette[3:0];
        endcase
      // underline attribute swaps blue foreground for a white underline
      UNDERLINE_EN_O  <= l400_uline_ok && line400[`LDC_L400_ULINE] &&
                         (ATTRIBUTE_BYTE_I == `LDC_ATTR_ULINE);
      BLUE_SUPPRESS_O <= l400_uline_ok && line400[`LDC_L400_ULINE] &&
                         (ATTRIBUTE_BYTE_I == `LDC_ATTR_ULINE);
    end
  end

endmodule // ldc_compat_regs

// file: pkg/ldc_regs.vh
// register offsets, bit positions and reset values of the legacy display compatibility block
`ifndef LDC_REGS_VH
`define LDC_REGS_VH
`define LDC_ADDR_VSE_PRI    16'h03C3
`define LDC_ADDR_VSE_ALT    16'h46E8
`define LDC_ADDR_CRT_IDX    16'h03B4
`define LDC_ADDR_CRT_DAT    16'h03B5
`define LDC_ADDR_MODE       16'h03B8
`define LDC_ADDR_STAT       16'h03BA
`define LDC_ADDR_MONO_MODE  16'h03B8
`define LDC_ADDR_PAGE_EN    16'h03BF
`define LDC_ADDR_COLR_MODE  16'h03D8
`define LDC_ADDR_PALETTE    16'h03D9
`define LDC_ADDR_LINE400    16'h03DE
`define LDC_PORT_HI         8'h03
`define LDC_NIB_CRT_IDX     4'h4
`define LDC_NIB_CRT_DAT     4'h5
`define LDC_NIB_STAT        4'hA
`define LDC_EMU_MONO_NIB    4'hB
`define LDC_EMU_COLR_NIB    4'hD
`define LDC_VSE_PRI_BIT     0
`define LDC_VSE_ALT_BIT     3
`define LDC_MODE_PAGE       7
`define LDC_MODE_PAGE_RB    6
`define LDC_MODE_BLINK      5
`define LDC_MODE_HIRES      4
`define LDC_MODE_VIDEO      3
`define LDC_MODE_BW         2
`define LDC_MODE_GFX        1
`define LDC_MODE_COL80      0
`define LDC_PAL_SET         5
`define LDC_PAL_INTENS      4
`define LDC_PAGE_EN_BIT     1
`define LDC_L400_ULINE      6
`define LDC_L400_PAGE       3
`define LDC_L400_FONT       2
`define LDC_L400_DSCAN      0
`define LDC_CCR_ULINE_EN    6
`define LDC_CCR_ENABLE      7
`define LDC_SYNC_NARROW     4
`define LDC_VSYNC_WIDE      5'h10
`define LDC_VSYNC_NARROW    5'h02
`define LDC_ATTR_ULINE      8'h01
`define LDC_RST_BYTE        8'h00
`define LDC_RST_VSE         8'h01
`define LDC_COL_CYAN        4'h3
`define LDC_COL_MAGENTA     4'h5
`define LDC_COL_WHITE       4'h7
`define LDC_COL_GREEN       4'h2
`define LDC_COL_RED         4'h4
`define LDC_COL_BROWN       4'h6
`define LDC_COL_INTENS      4'h8
`endif

// file: verif/ldc_host_model.sv
// host i/o master model for the compat register ports
`timescale 1ns/1ps
module ldc_host_model
(
  input  wire         clk_i,
  input  wire         ack_i,
  input  wire  [7:0]  rdata_i,
  output logic [15:0] addr_o,
  output logic        wr_o,
  output logic        rd_o,
  output logic [7:0]  wdata_o
);
  // idle bus at time zero
  initial
  begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // one-cycle strobe; released address and data lines show the inverse so stale values never look valid
  task acc(input logic [15:0] a, input logic w, input logic [7:0] d, output logic k, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge clk_i);
    k = ack_i;
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    @(posedge clk_i);
    q = rdata_i;
  endtask
endmodule // ldc_host_model

// file: verif/ldc_compat_regs_monitor.sv
// port-level assertions for the compat register block
`timescale 1ns/1ps
`include "ldc_regs.vh"
module ldc_compat_regs_chk
(
  input wire        MCLK_I,
  input wire        RST_B_I,
  input wire [15:0] IO_ADDR_I,
  input wire        IO_WR_I,
  input wire        IO_RD_I,
  input wire [7:0]  IO_WDATA_I,
  input wire [7:0]  IO_RDATA_O,
  input wire        IO_ACK_O,
  input wire        ADDR_SELECT_COLOR_I,
  input wire        SYNC_WIDTH_NARROW_I,
  input wire        VIDEO_ENABLE_O,
  input wire        CRT_IDX_SEL_O,
  input wire        STATUS_SEL_O,
  input wire        GRAPHICS_MODE_O,
  input wire        UPPER_PAGE_O,
  input wire        SECOND_PAGE_EN_O,
  input wire [4:0]  VSYNC_LINES_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  // port nibbles of the active and the inactive emulation
  wire [3:0] emu = ADDR_SELECT_COLOR_I ? 4'hD : 4'hB;
  wire [3:0] oth = ADDR_SELECT_COLOR_I ? 4'hB : 4'hD;
  wire       stb = IO_WR_I | IO_RD_I;
  ////////////////////////////////////////
  // accepted accesses to the colour mode port
  sequence colr_wr;
    IO_WR_I && IO_ACK_O && IO_ADDR_I == `LDC_ADDR_COLR_MODE;
  endsequence
  sequence colr_rd;
    IO_RD_I && IO_ACK_O && IO_ADDR_I == `LDC_ADDR_COLR_MODE;
  endsequence
  crt_index_a: assert property (stb && VIDEO_ENABLE_O && IO_ADDR_I == {8'h03, emu, 4'h4} |-> CRT_IDX_SEL_O)
    else $error("index port not decoded");
  status_range_a: assert property (IO_ADDR_I == {8'h03, oth, 4'hA} |-> !STATUS_SEL_O)
    else $error("status decoded in wrong range");
  gated_off_a: assert property (!VIDEO_ENABLE_O && stb && IO_ADDR_I == `LDC_ADDR_COLR_MODE |-> !IO_ACK_O)
    else $error("access answered while disabled");
  palette_ack_a: assert property (IO_WR_I && VIDEO_ENABLE_O && ADDR_SELECT_COLOR_I
    && IO_ADDR_I == `LDC_ADDR_PALETTE |-> IO_ACK_O)
    else $error("palette write not taken");
  mode_follow_a: assert property (colr_wr |-> ##2 GRAPHICS_MODE_O == $past(IO_WDATA_I[1], 2))
    else $error("graphics mode did not follow write");
  page_readback_a: assert property (colr_rd |=> IO_RDATA_O[7:6] == {1'b0, SECOND_PAGE_EN_O})
    else $error("page bit not mirrored in read");
  upper_lock_a: assert property (!SECOND_PAGE_EN_O [*3] |-> !UPPER_PAGE_O)
    else $error("upper page without page enable");
  vsync_narrow_a: assert property (SYNC_WIDTH_NARROW_I |=> VSYNC_LINES_O == `LDC_VSYNC_NARROW)
    else $error("narrow sync width wrong");
  vsync_wide_a: assert property (!SYNC_WIDTH_NARROW_I |=> VSYNC_LINES_O == `LDC_VSYNC_WIDE)
    else $error("wide sync width wrong");
endmodule // ldc_compat_regs_chk
bind ldc_compat_regs ldc_compat_regs_chk u_chk (.*);

// file: verif/tb_ldc_compat_regs.sv
// self-checking bench for the compat register block
`timescale 1ns/1ps
`include "ldc_regs.vh"
module tb_ldc_compat_regs;
  logic MCLK_I = 1'b0, RST_B_I = 1'b0, ADDR_SELECT_COLOR_I = 1'b1, VSE_ALT_PORT_I = 1'b0, SYNC_WIDTH_NARROW_I = 1'b0;
  logic [7:0] COMPAT_CONTROL_I = 8'h00, ATTRIBUTE_BYTE_I = 8'h00;
  logic [1:0] PIXEL_CODE_I = 2'h0;
  wire [15:0] IO_ADDR_I;
  wire [7:0] IO_WDATA_I, IO_RDATA_O;
  wire [3:0] PIXEL_COLOR_O, BASE_COLOR_O;
  wire [4:0] VSYNC_LINES_O;
  wire IO_WR_I, IO_RD_I, IO_ACK_O, VIDEO_ENABLE_O, CRT_IDX_SEL_O, CRT_DAT_SEL_O, STATUS_SEL_O, BLINK_ENABLE_O;
  wire VIDEO_KEEP_O, HIRES_MODE_O, BW_MODE_O, GRAPHICS_MODE_O, COL80_MODE_O, UPPER_PAGE_O, SECOND_PAGE_EN_O;
  wire UNDERLINE_EN_O, BLUE_SUPPRESS_O, ALT_PAGE_O, ALT_FONT_O, DOUBLE_SCAN_O;
  int fail_count = 0, checks_done = 0, cycles = 0;
  logic ak;
  logic [7:0] rq;
  ldc_compat_regs DUT (.*);
  ldc_host_model host (.clk_i(MCLK_I), .ack_i(IO_ACK_O), .rdata_i(IO_RDATA_O), .addr_o(IO_ADDR_I),
    .wr_o(IO_WR_I), .rd_o(IO_RD_I), .wdata_o(IO_WDATA_I));
  always #10 MCLK_I = ~MCLK_I;
  // hang guard: the sequence needs under 1500 cycles
  always @(posedge MCLK_I)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fail_count++;
      conclude();
    end
  end
  ////////////////////////////////////////
  task conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // outputs lag their register by a cycle, so three edges leave margin
  task settle();
    repeat (3) @(posedge MCLK_I);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    host.acc(a, 1'b1, d, ak, rq);
    settle();
  endtask
  task rd(input logic [15:0] a);
    host.acc(a, 1'b0, 8'h00, ak, rq);
    settle();
  endtask
  ////////////////////////////////////////
  task t_color();
    logic [7:0] d;
    chk("vsync reset", 8'h10, {3'h0, VSYNC_LINES_O});
    for (int i = 0; i < 2; i++)
    begin
      d = i ? 8'hFF : 8'h2A;
      wr(`LDC_ADDR_COLR_MODE, d);
      chk("mode bits", {2'h0, d[5:0]}, {2'h0, BLINK_ENABLE_O, HIRES_MODE_O, VIDEO_KEEP_O, BW_MODE_O,
        GRAPHICS_MODE_O, COL80_MODE_O});
      rd(`LDC_ADDR_COLR_MODE);
      chk("mode read", {2'h0, d[5:0]}, rq);
    end
    rd(`LDC_ADDR_PALETTE);
    chk("palette read", 8'h00, rq);
  endtask
  task t_mono();
    ADDR_SELECT_COLOR_I = 1'b0;
    wr(`LDC_ADDR_MONO_MODE, 8'h80);
    chk("page locked", 8'h00, {7'h0, UPPER_PAGE_O});
    wr(`LDC_ADDR_COLR_MODE, 8'h00);
    chk("colour port in mono", 8'h00, {7'h0, ak});
    wr(`LDC_ADDR_PAGE_EN, 8'h02);
    chk("second page", 8'h01, {7'h0, SECOND_PAGE_EN_O});
    wr(`LDC_ADDR_MONO_MODE, 8'h83);
    chk("mono mode", 8'h07, {5'h0, UPPER_PAGE_O, GRAPHICS_MODE_O, COL80_MODE_O});
    rd(`LDC_ADDR_MONO_MODE);
    chk("mono read", 8'hC3, rq);
    wr(`LDC_ADDR_MONO_MODE, 8'h00);
    wr(`LDC_ADDR_PAGE_EN, 8'h00);
    ADDR_SELECT_COLOR_I = 1'b1;
    wr(`LDC_ADDR_COLR_MODE, 8'h02);
  endtask
  task t_palette();
    logic [3:0] e;
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 4; c++)
      begin
        wr(`LDC_ADDR_PALETTE, {2'h0, m[1:0], 4'h9});
        PIXEL_CODE_I = c[1:0];
        settle();
        e = (c == 0) ? 4'h9 : {m[0], c[1:0], m[1]};
        chk("pixel colour", {4'h0, e}, {4'h0, PIXEL_COLOR_O});
        chk("base colour", 8'h09, {4'h0, BASE_COLOR_O});
      end
  endtask
  // colour emulation is held throughout the 400-line programming
  task t_line400();
    wr(`LDC_ADDR_LINE400, 8'h4D);
    chk("l400 gated", 8'h00, {4'h0, UNDERLINE_EN_O, ALT_PAGE_O, ALT_FONT_O, DOUBLE_SCAN_O});
    COMPAT_CONTROL_I = 8'hC0;
    ATTRIBUTE_BYTE_I = `LDC_ATTR_ULINE;
    wr(`LDC_ADDR_LINE400, 8'h4D);
    chk("l400 on", 8'h1B, {3'h0, BLUE_SUPPRESS_O, UNDERLINE_EN_O, ALT_PAGE_O, ALT_FONT_O,
      DOUBLE_SCAN_O});
    COMPAT_CONTROL_I = 8'h40;
    settle();
    chk("l400 ul only", 8'h18, {3'h0, BLUE_SUPPRESS_O, UNDERLINE_EN_O, ALT_PAGE_O, ALT_FONT_O,
      DOUBLE_SCAN_O});
    COMPAT_CONTROL_I = 8'h80;
    wr(`LDC_ADDR_LINE400, 8'h0C);
    chk("alt page", 8'h06, {4'h0, UNDERLINE_EN_O, ALT_PAGE_O, ALT_FONT_O, DOUBLE_SCAN_O});
  endtask
  task t_enable();
    SYNC_WIDTH_NARROW_I = 1'b1;
    rd(16'h03D4);
    chk("index ack", 8'h01, {7'h0, ak});
    chk("vsync narrow", 8'h02, {3'h0, VSYNC_LINES_O});
    rd(16'h03BA);
    chk("mono status in colour", 8'h00, {7'h0, ak});
    wr(`LDC_ADDR_VSE_PRI, 8'h00);
    chk("video off", 8'h00, {7'h0, VIDEO_ENABLE_O});
    rd(`LDC_ADDR_COLR_MODE);
    chk("disabled ack", 8'h00, {7'h0, ak});
    VSE_ALT_PORT_I = 1'b1;
    wr(`LDC_ADDR_VSE_ALT, 8'h09);
    chk("alt enable", 8'h01, {7'h0, VIDEO_ENABLE_O});
    VSE_ALT_PORT_I = 1'b0;
    settle();
    chk("pri enable", 8'h01, {7'h0, VIDEO_ENABLE_O});
  endtask
  // reset for 20 cycles, then every scenario in turn
  initial
  begin
    repeat (20) @(posedge MCLK_I);
    #1;
    RST_B_I = 1'b1;
    settle();
    t_color();
    t_mono();
    t_palette();
    t_line400();
    t_enable();
    conclude();
  end
endmodule // tb_ldc_compat_regs
